/* rtl/math_pkg.sv */
// Purpose: shared types and constants for reading math and analog scaling
// Assumes: readings and coefficients are signed Q16.16 fixed point
// Notes: dac codes are offset binary, code 0 is the negative full-scale end
package math_pkg;
   localparam int VAL_W = 32;                  // reading width
   localparam int FRAC_W = 16;                 // fractional bits
   localparam int DAC_W = 14;                  // converter width
   localparam int NOUT = 2;                    // analog outputs
   localparam logic [DAC_W-1:0] DAC_ZERO = 14'h2000;  // 0 V
   localparam logic [DAC_W-1:0] DAC_TOP = 14'h3fff;   // +10 V
   localparam logic [DAC_W-1:0] DAC_BOT = 14'h0000;   // -10 V
   localparam logic signed [VAL_W-1:0] SLOPE_RST = 32'h0001_0000;  // 1.0
   localparam logic signed [VAL_W-1:0] OFFSET_RST = 32'h0000_0000; // 0.0
   localparam logic signed [VAL_W-1:0] COEF_MAX = 32'h270f_e666;   // 9999.9
   localparam logic [6:0] PTS_MIN = 7'h02;     // fewest filter points
   localparam logic [6:0] PTS_MAX = 7'h40;     // most filter points
   localparam logic [3:0] WIN_MIN = 4'h1;      // window 1 %
   localparam logic [3:0] WIN_MAX = 4'ha;      // window 10 %
   localparam logic signed [15:0] PCT_FULL = 16'sh2710; // 100.00 % in 0.01 %
   localparam logic [VAL_W-1:0] FS_RST = 32'h03e8_0000; // full scale default
   // reading source selector
   typedef enum logic [1:0] {SRC_K, SRC_C, SRC_S, SRC_LIN} src_t;
   typedef enum logic [1:0] {AO_OFF, AO_FOLLOW, AO_MANUAL} ao_mode_t;
   // one reading set, from the conversion stage
   typedef struct packed {
      logic signed [VAL_W-1:0] kel;
      logic signed [VAL_W-1:0] cel;
      logic signed [VAL_W-1:0] sen;
   } reading_t;
   // per input math settings
   typedef struct packed {
      src_t lin_src;
      src_t mm_src;
      logic signed [VAL_W-1:0] slope;
      logic signed [VAL_W-1:0] offset;
      logic filt_en;
      logic [6:0] filt_pts;
      logic [3:0] filt_win;
      logic [VAL_W-1:0] full_scale;
   } in_cfg_t;
   // per analog output settings
   typedef struct packed {
      ao_mode_t mode;
      logic bipolar;
      logic [2:0] in_sel;
      src_t src;
      logic signed [VAL_W-1:0] lo;
      logic signed [VAL_W-1:0] hi;
      logic signed [15:0] man_pct;
   } ao_cfg_t;
endpackage

/* rtl/reading_math.sv */
// Purpose: per input linear, filter and max/min math plus analog output codes
// Assumes: one reading per input update, inputs synchronous to mclk
// Notes: all arithmetic is single cycle; results appear one edge later
`timescale 1ns/1ps
`default_nettype none
module reading_math #(
   parameter int NCH = 8
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic rd_valid,
   input wire logic [2:0] rd_ch,
   input wire math_pkg::reading_t rd_in,
   input wire logic cfg_wr,
   input wire logic [2:0] cfg_ch,
   input wire math_pkg::in_cfg_t cfg_in,
   input wire logic [NCH-1:0] mm_clear_req,
   input wire math_pkg::ao_cfg_t ao_cfg [math_pkg::NOUT],
   output logic out_valid,
   output logic [2:0] out_ch,
   output logic signed [math_pkg::VAL_W-1:0] out_val [4],
   output logic signed [math_pkg::VAL_W-1:0] max_val [NCH],
   output logic signed [math_pkg::VAL_W-1:0] min_val [NCH],
   output logic [NCH-1:0] mm_valid,
   output logic [math_pkg::DAC_W-1:0] dac_code [math_pkg::NOUT]
);
   import math_pkg::*;

   // the three-bit input number cannot address more than eight inputs
   generate
      if (NCH < 1 || NCH > 8)
      begin : g_bad_nch
         $error("NCH must lie between 1 and 8");
      end
   endgenerate

   in_cfg_t cfg_reg [NCH];                     // stored input settings
   in_cfg_t cfg_next;                          // write value after limits
   logic signed [VAL_W-1:0] val_reg [NCH][4];  // latest results per source
   logic [NCH-1:0] prim_reg;                   // filter holds a value
   logic signed [VAL_W-1:0] x_raw [4];         // incoming values, lin last
   logic signed [VAL_W-1:0] x_new [4];         // after filter
   logic [3:0] restart;                        // per source restart
   logic signed [2*VAL_W-1:0] lin_prod;        // slope product
   logic signed [VAL_W-1:0] lin_x;             // linear variable
   logic cfg_chg;                              // write altered settings
   in_cfg_t cur;                               // settings of arriving input

   // magnitude limit of a coefficient
   function automatic logic signed [VAL_W-1:0] clip(input logic signed [VAL_W-1:0] v);
      if (v > COEF_MAX)
         return COEF_MAX;
      else if (v < -COEF_MAX)
         return -COEF_MAX;
      else
         return v;
   endfunction

   // settings write is limited so the datapath never sees illegal lengths
   always_comb
   begin
      cfg_next = cfg_in;
      cfg_next.slope = clip(cfg_in.slope);
      cfg_next.offset = clip(cfg_in.offset);
      if (cfg_in.filt_pts < PTS_MIN)
         cfg_next.filt_pts = PTS_MIN;
      else if (cfg_in.filt_pts > PTS_MAX)
         cfg_next.filt_pts = PTS_MAX;
      if (cfg_in.filt_win < WIN_MIN)
         cfg_next.filt_win = WIN_MIN;
      else if (cfg_in.filt_win > WIN_MAX)
         cfg_next.filt_win = WIN_MAX;
      // sensor-unit source stands in for an illegal linear variable
      if (cfg_in.lin_src == SRC_LIN)
         cfg_next.lin_src = SRC_S;
   end

   assign cfg_chg = cfg_wr && (32'(cfg_ch) < NCH) && (cfg_reg[cfg_ch] != cfg_next);
   assign cur = cfg_reg[rd_ch];

   // settings store, defaults slope one and offset zero
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < NCH; i++)
         begin
            cfg_reg[i] <= '{SRC_K, SRC_K, SLOPE_RST, OFFSET_RST, 1'b0, PTS_MIN, WIN_MIN, FS_RST};
         end
      end
      else if (cfg_wr && 32'(cfg_ch) < NCH)
         cfg_reg[cfg_ch] <= cfg_next;
   end

   // linear equation on the arriving reading
   always_comb
   begin
      x_raw[0] = rd_in.kel;
      x_raw[1] = rd_in.cel;
      x_raw[2] = rd_in.sen;
      case (cur.lin_src)
         SRC_K: lin_x = rd_in.kel;
         SRC_C: lin_x = rd_in.cel;
         default: lin_x = rd_in.sen;
      endcase
      lin_prod = cur.slope * lin_x;
      x_raw[3] = (VAL_W)'(lin_prod >>> FRAC_W) + cur.offset;
   end

   // exponential smoothing, one lane per source
   genvar s;
   generate
      for (s = 0; s < 4; s++)
      begin : g_filt
         logic signed [VAL_W:0] diff;          // new minus filtered
         logic [VAL_W:0] mag;                  // its magnitude
         logic [2*VAL_W-1:0] lim;              // window in value units
         logic signed [VAL_W:0] step;          // filter increment
         always_comb
         begin
            diff = (VAL_W+1)'(x_raw[s]) - (VAL_W+1)'(val_reg[rd_ch][s]);
            mag = diff[VAL_W] ? (VAL_W+1)'(-diff) : diff;
            lim = (2*VAL_W)'((64'(cur.full_scale) * 64'(cur.filt_win)) / 64'd100);
            // restart beyond window, or first value
            restart[s] = !prim_reg[rd_ch] || (64'(mag) > lim);
            // weight of one new point is 1/N
            step = diff / $signed({26'h0, cur.filt_pts});
            if (!cur.filt_en || restart[s])
               x_new[s] = x_raw[s];
            else
               x_new[s] = val_reg[rd_ch][s] + (VAL_W)'(step);
         end
      end
   endgenerate

   // every reading updates its input once
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         prim_reg <= '0;
         for (int i = 0; i < NCH; i++)
            for (int j = 0; j < 4; j++)
               val_reg[i][j] <= '0;
      end
      else if (rd_valid && 32'(rd_ch) < NCH)
      begin
         prim_reg[rd_ch] <= 1'b1;
         for (int j = 0; j < 4; j++)
            val_reg[rd_ch][j] <= x_new[j];
      end
   end

   // result strobe, data from flops
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         out_valid <= 1'b0;
         out_ch <= 3'h0;
         for (int j = 0; j < 4; j++)
            out_val[j] <= '0;
      end
      else
      begin
         out_valid <= rd_valid && 32'(rd_ch) < NCH;
         if (rd_valid)
         begin
            out_ch <= rd_ch;
            for (int j = 0; j < 4; j++)
               out_val[j] <= x_new[j];
         end
      end
   end

   // max/min capture; a reading in the clear cycle reloads, so it is kept
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         mm_valid <= '0;
         for (int i = 0; i < NCH; i++)
         begin
            max_val[i] <= '0;
            min_val[i] <= '0;
         end
      end
      else
      begin
         for (int i = 0; i < NCH; i++)
         begin
            if (rd_valid && 32'(rd_ch) == i)
            begin
               if (!mm_valid[i] || mm_clear_req[i] || (cfg_chg && 32'(cfg_ch) == i))
               begin
                  max_val[i] <= x_new[cfg_reg[i].mm_src];
                  min_val[i] <= x_new[cfg_reg[i].mm_src];
               end
               else
               begin
                  if (x_new[cfg_reg[i].mm_src] > max_val[i])
                     max_val[i] <= x_new[cfg_reg[i].mm_src];
                  if (x_new[cfg_reg[i].mm_src] < min_val[i])
                     min_val[i] <= x_new[cfg_reg[i].mm_src];
               end
               mm_valid[i] <= 1'b1;
            end
            else if (mm_clear_req[i])
               mm_valid[i] <= 1'b0;
            else if (cfg_chg && 32'(cfg_ch) == i)
               mm_valid[i] <= 1'b0;
         end
      end
   end

   // analog outputs, each independent
   // own settings per output
   genvar o;
   generate
      for (o = 0; o < NOUT; o++)
      begin : g_ao
         logic [DAC_W-1:0] code;               // next code
         logic [DAC_W-1:0] bot;                // range bottom
         logic signed [VAL_W-1:0] x;           // followed value
         logic signed [VAL_W:0] den;           // high minus low
         logic signed [2*VAL_W+1:0] num;       // scaled offset from low
         logic signed [31:0] man;              // manual code offset
         always_comb
         begin
            // bipolar reaches -10 V, unipolar stops at 0 V
            bot = ao_cfg[o].bipolar ? DAC_BOT : DAC_ZERO;
            x = (32'(ao_cfg[o].in_sel) < NCH) ? val_reg[ao_cfg[o].in_sel][ao_cfg[o].src] : '0;
            den = (VAL_W+1)'(ao_cfg[o].hi) - (VAL_W+1)'(ao_cfg[o].lo);
            num = ((2*VAL_W+2)'(x) - (2*VAL_W+2)'(ao_cfg[o].lo)) * (2*VAL_W+2)'(DAC_TOP - bot);
            // 0.01 % steps over +-10 V
            man = (32'(ao_cfg[o].man_pct) * 32'sd8192) / 32'(PCT_FULL);
            code = DAC_ZERO;
            case (ao_cfg[o].mode)
               AO_OFF: code = DAC_ZERO;
               AO_MANUAL:
               begin
                  // unipolar clips at zero; clip at top
                  // signed sums, so a large negative percent cannot wrap to the top
                  if (int'(DAC_ZERO) + man >= int'(DAC_TOP))
                     code = DAC_TOP;
                  else if (int'(DAC_ZERO) + man <= int'(bot))
                     code = bot;
                  else
                     code = DAC_W'(int'(DAC_ZERO) + man);
               end
               AO_FOLLOW:
               begin
                  if (x <= ao_cfg[o].lo || den <= 0)
                     code = bot;
                  else if (x >= ao_cfg[o].hi)
                     code = DAC_TOP;
                  else
                     code = bot + DAC_W'(num / (2*VAL_W+2)'(den));
               end
               default: code = DAC_ZERO;
            endcase
         end
         always_ff @(posedge mclk or negedge resetn)
         begin
            if (!resetn)
               dac_code[o] <= DAC_ZERO;
            else
               dac_code[o] <= code;
         end
      end
   endgenerate

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   property p_mm_order;
      mm_valid[0] |-> max_val[0] >= min_val[0];
   endproperty
   a_mm_order: assert property (p_mm_order) else $error("max below min");

   property p_clear;
      mm_clear_req[0] && !(rd_valid && rd_ch == 3'h0) |=> !mm_valid[0];
   endproperty
   a_clear: assert property (p_clear) else $error("manual clear lost");

   property p_cfg_clear;
      cfg_chg && cfg_ch == 3'h0 && !(rd_valid && rd_ch == 3'h0) |=> !mm_valid[0];
   endproperty
   a_cfg_clear: assert property (p_cfg_clear) else $error("settings change kept max/min");

   property p_rate;
      rd_valid && rd_ch == 3'h0 |=> out_valid && out_ch == 3'h0;
   endproperty
   a_rate: assert property (p_rate) else $error("reading without result");

   property p_pass;
      rd_valid && rd_ch == 3'h0 && !cfg_reg[0].filt_en |=> out_val[0] == $past(rd_in.kel);
   endproperty
   a_pass: assert property (p_pass) else $error("unfiltered value altered");

   property p_restart;
      rd_valid && rd_ch == 3'h0 && restart[1] |=> out_val[1] == $past(rd_in.cel, 1);
   endproperty
   a_restart: assert property (p_restart) else $error("filter not restarted");

   property p_off;
      ao_cfg[0].mode == AO_OFF ##1 ao_cfg[0].mode == AO_OFF |-> dac_code[0] == DAC_ZERO;
   endproperty
   a_off: assert property (p_off) else $error("off output not at zero");

   property p_unipolar;
      !$past(ao_cfg[1].bipolar) && $past(ao_cfg[1].mode) != AO_OFF |-> dac_code[1] >= DAC_ZERO;
   endproperty
   a_unipolar: assert property (p_unipolar) else $error("unipolar went negative");

   property p_sat_hi;
      ao_cfg[1].mode == AO_FOLLOW && g_ao[1].x >= ao_cfg[1].hi && ao_cfg[1].hi > ao_cfg[1].lo
         |=> dac_code[1] == DAC_TOP;
   endproperty
   a_sat_hi: assert property (p_sat_hi) else $error("high end not at top");
endmodule
`default_nettype wire

/* sim/dac_model.sv */
// Purpose: behavioural model of the 14-bit bipolar output converter
// Assumes: offset binary code, mid code is 0 V
// Notes: output kept in microvolts so the 1.25 mV step stays exact
`timescale 1ns/1ps
`default_nettype none
module dac_model
(
   input wire logic [math_pkg::DAC_W-1:0] code,
   output var int out_uv
);
   import math_pkg::*;
   // code to voltage
   // plain integer maths, no rounding, so a wrong code shows directly
   always_comb
   begin
      out_uv = (int'(code) - int'(DAC_ZERO)) * 1250;
   end
endmodule
`default_nettype wire

/* sim/testbench.sv */
// Purpose: self-checking bench for reading math and analog scaling
// Assumes: Q16.16 readings, offset binary converter codes
// Notes: each scenario is a task that drives and judges on its own
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      check_count++; \
      if ((got) !== (exp)) \
      begin \
         bad_count++; \
         $display("Error at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module testbench;
   import math_pkg::*;
   logic mclk = 1'b0; // 200 MHz clock
   logic resetn = 1'b0; // held low at start
   logic rd_valid = 1'b0;
   logic [2:0] rd_ch = 3'h0;
   reading_t rd_in = '0;
   logic cfg_wr = 1'b0;
   logic [2:0] cfg_ch = 3'h0;
   in_cfg_t cfg_in = '0;
   logic [7:0] mm_clear_req = 8'h00;
   ao_cfg_t ao_cfg [NOUT] = '{default: '0}; // both outputs off
   logic out_valid;
   logic [2:0] out_ch;
   logic signed [VAL_W-1:0] out_val [4];
   logic signed [VAL_W-1:0] max_val [8];
   logic signed [VAL_W-1:0] min_val [8];
   logic [7:0] mm_valid;
   logic [DAC_W-1:0] dac_code [NOUT];
   int uv0; // converter voltage in microvolts
   int uv1;
   int bad_count = 0;
   int check_count = 0;
   int cycles = 0;
   reading_math #(.NCH(8)) u_reading_math (.mclk(mclk), .resetn(resetn), .rd_valid(rd_valid), .rd_ch(rd_ch),
      .rd_in(rd_in), .cfg_wr(cfg_wr), .cfg_ch(cfg_ch), .cfg_in(cfg_in), .mm_clear_req(mm_clear_req),
      .ao_cfg(ao_cfg), .out_valid(out_valid), .out_ch(out_ch), .out_val(out_val), .max_val(max_val),
      .min_val(min_val), .mm_valid(mm_valid), .dac_code(dac_code));
   dac_model u_dac_model (.code(dac_code[0]), .out_uv(uv0));
   dac_model u_dac_model_b (.code(dac_code[1]), .out_uv(uv1));
   // free running clock
   always #2.5 mclk = ~mclk;
   // hang guard, far above the roughly 135 cycles the tests need
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         bad_count++;
         results();
      end
   end
   // settings as after reset
   function automatic in_cfg_t dflt();
      in_cfg_t c;
      c = '0;
      c.lin_src = SRC_K;
      c.mm_src = SRC_K;
      c.slope = SLOPE_RST;
      c.offset = OFFSET_RST;
      c.filt_pts = PTS_MIN;
      c.filt_win = WIN_MIN;
      c.full_scale = FS_RST;
      return c;
   endfunction
   // one reading pulse; returns at the edge that shows the result
   task automatic rd(input logic [2:0] ch, input logic signed [31:0] k, c, s);
      @(posedge mclk);
      #1;
      rd_valid = 1'b1;
      rd_ch = ch;
      rd_in = '{kel: k, cel: c, sen: s};
      @(posedge mclk);
      #1;
      rd_valid = 1'b0;
   endtask
   // one settings write pulse
   task automatic wr(input logic [2:0] ch, input in_cfg_t c);
      @(posedge mclk);
      #1;
      cfg_wr = 1'b1;
      cfg_ch = ch;
      cfg_in = c;
      @(posedge mclk);
      #1;
      cfg_wr = 1'b0;
   endtask
   // analog output setting, then let the code settle
   task automatic ao(input int i, input ao_mode_t m, input logic b, input logic signed [15:0] p,
      input logic signed [31:0] lo, hi);
      @(posedge mclk);
      #1;
      ao_cfg[i] = '{m, b, 3'h0, SRC_K, lo, hi, p};
      repeat (2) @(posedge mclk);
      #1;
   endtask
   // reset state and default coefficients
   task automatic t_reset();
      `CHK(dac_code[0], DAC_ZERO)
      `CHK(mm_valid, 8'h00)
      rd(3'h0, 32'h000a_0000, 32'h0003_0000, 32'h0004_0000);
      `CHK(out_val[3], 32'sh000a_0000)
      @(posedge mclk);
      #1;
      `CHK(out_valid, 1'b0)
      $display("test reset done");
   endtask
   // slope, offset, every source, coefficient clamp
   task automatic t_lin();
      in_cfg_t c;
      src_t srcs [4] = '{SRC_K, SRC_C, SRC_S, SRC_LIN};
      logic signed [31:0] exp [4] = '{32'sh0015_0000, 32'sh0007_0000, 32'sh0009_0000, 32'sh0009_0000};
      c = dflt();
      c.slope = 32'sh0002_0000;
      c.offset = 32'sh0001_0000;
      for (int i = 0; i < 4; i++)
      begin
         c.lin_src = srcs[i];
         wr(3'h0, c);
         rd(3'h0, 32'h000a_0000, 32'h0003_0000, 32'h0004_0000);
         `CHK(out_valid, 1'b1)
         `CHK(out_val[0], 32'sh000a_0000)
         `CHK(out_val[3], exp[i])
      end
      c.lin_src = SRC_K;
      c.slope = 32'sh7fff_0000;
      wr(3'h0, c);
      rd(3'h0, 32'h0001_0000, 32'h0, 32'h0);
      `CHK(out_val[3], COEF_MAX + 32'sh0001_0000)
      $display("test linear done");
   endtask
   // capture, manual clear, clear on changed settings
   task automatic t_mm();
      in_cfg_t c;
      c = dflt();
      wr(3'h1, c);
      rd(3'h1, 32'h0005_0000, 32'h0, 32'h0);
      rd(3'h1, 32'h0009_0000, 32'h0, 32'h0);
      rd(3'h1, 32'h0003_0000, 32'h0, 32'h0);
      `CHK(out_ch, 3'h1)
      `CHK(max_val[1], 32'sh0009_0000)
      `CHK(min_val[1], 32'sh0003_0000)
      @(posedge mclk);
      #1;
      mm_clear_req = 8'h02;
      @(posedge mclk);
      #1;
      mm_clear_req = 8'h00;
      `CHK(mm_valid[1], 1'b0)
      rd(3'h1, 32'h0007_0000, 32'h0, 32'h0);
      `CHK(max_val[1], 32'sh0007_0000)
      wr(3'h1, c);
      `CHK(mm_valid[1], 1'b1)
      c.offset = 32'sh0002_0000;
      c.mm_src = SRC_C;
      wr(3'h1, c);
      `CHK(mm_valid[1], 1'b0)
      // capture now follows the celsius value
      rd(3'h1, 32'h0001_0000, 32'h0006_0000, 32'h0);
      `CHK(max_val[1], 32'sh0006_0000)
      $display("test maxmin done");
   endtask
   // smoothing, restart window, settling
   task automatic t_filt();
      in_cfg_t c;
      c = dflt();
      c.filt_en = 1'b1;
      c.filt_pts = 7'h04;
      c.filt_win = 4'ha;
      wr(3'h2, c);
      rd(3'h2, 32'h0008_0000, 32'h0008_0000, 32'h0);
      `CHK(out_val[0], 32'sh0008_0000)
      rd(3'h2, 32'h000c_0000, 32'h000c_0000, 32'h0);
      `CHK(out_val[0], 32'sh0009_0000)
      `CHK(out_val[1], 32'sh0009_0000)
      rd(3'h2, 32'h01f4_0000, 32'h01f4_0000, 32'h0);
      `CHK(out_val[0], 32'sh01f4_0000)
      rd(3'h2, 32'h01c2_0000, 32'h01c2_0000, 32'h0);
      `CHK(out_val[0], 32'sh01e7_8000)
      repeat (23) rd(3'h2, 32'h01c2_0000, 32'h01c2_0000, 32'h0);
      `CHK(out_val[0] - 32'sh01c2_0000 < 32'sh0000_1999, 1'b1)
      $display("test filter done");
   endtask
   // manual mapping on output 0, follow mapping on output 1
   task automatic t_ao();
      rd(3'h0, 32'h0032_0000, 32'h0, 32'h0);
      ao(0, AO_MANUAL, 1'b1, 16'sh1388, 32'sh0, 32'sh0);
      `CHK(dac_code[0], 14'h3000)
      `CHK(uv0, 5120000)
      ao(1, AO_FOLLOW, 1'b0, 16'sh0, 32'sh0, 32'sh0064_0000);
      `CHK(dac_code[1], 14'h2fff)
      `CHK(dac_code[0], 14'h3000)
      ao(1, AO_FOLLOW, 1'b1, 16'sh0, 32'sh0, 32'sh0064_0000);
      `CHK(dac_code[1], 14'h1fff)
      ao(1, AO_FOLLOW, 1'b1, 16'sh0, 32'sh0, 32'sh0028_0000);
      `CHK(dac_code[1], 14'h3fff)
      ao(1, AO_FOLLOW, 1'b1, 16'sh0, 32'sh0046_0000, 32'sh0064_0000);
      `CHK(dac_code[1], 14'h0000)
      `CHK(uv1, -10240000)
      ao(1, AO_FOLLOW, 1'b0, 16'sh0, 32'sh0046_0000, 32'sh0064_0000);
      `CHK(dac_code[1], DAC_ZERO)
      ao(0, AO_MANUAL, 1'b1, 16'shd8f0, 32'sh0, 32'sh0);
      `CHK(dac_code[0], 14'h0000)
      ao(0, AO_MANUAL, 1'b0, 16'shec78, 32'sh0, 32'sh0);
      `CHK(dac_code[0], DAC_ZERO)
      // follow input 1 celsius: 8 of 0..32 bipolar
      rd(3'h1, 32'h0004_0000, 32'h0008_0000, 32'h000c_0000);
      ao(1, AO_FOLLOW, 1'b1, 16'sh0, 32'sh0, 32'sh0020_0000);
      ao_cfg[1].in_sel = 3'h1;
      ao_cfg[1].src = SRC_C;
      repeat (2) @(posedge mclk);
      #1;
      `CHK(dac_code[1], 14'h0fff)
      ao(1, AO_OFF, 1'b1, 16'sh0, 32'sh0, 32'sh0064_0000);
      `CHK(dac_code[1], DAC_ZERO)
      $display("test analog done");
   endtask
   // verdict and end of run
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // main sequence
   initial
   begin
      cfg_in = dflt();
      repeat (2) @(posedge mclk);
      #1;
      resetn = 1'b1;
      t_reset();
      t_lin();
      t_mm();
      t_filt();
      t_ao();
      results();
   end
endmodule
`default_nettype wire
